// file: dps_consts.svh
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH

// Command byte opcodes, upper nibble
`define DPS_OP_RD_WCR    4'h9
`define DPS_OP_WR_WCR    4'ha
`define DPS_OP_RD_DR     4'hb
`define DPS_OP_WR_DR     4'hc
`define DPS_OP_XFR_D2W   4'hd
`define DPS_OP_XFR_W2D   4'he
`define DPS_OP_GXFR_D2W  4'h1
`define DPS_OP_GXFR_W2D  4'h8

// Field positions in the address and command bytes
`define DPS_TYPE_HI      7
`define DPS_TYPE_LO      4
`define DPS_STRAP_HI     3
`define DPS_STRAP_LO     0
`define DPS_OP_HI        7
`define DPS_OP_LO        4
`define DPS_SEL_HI_POS   3
`define DPS_SEL_LO_POS   2
`define DPS_POT_POS      0

// Bit counter values within one byte frame
`define DPS_BIT_LAST     4'h7
`define DPS_BIT_ACK      4'h8

// Reset values
`define DPS_SETTING_RESET 8'h80
`define DPS_TAP_RESET     256'h1

// Timing: nonvolatile write time and system clock rate
`define DPS_NV_WRITE_MS   10
`define DPS_SYS_CLK_KHZ   200000

`endif

// file: dps_pkg.sv
package dps_pkg;

	typedef enum logic [2:0] {
		DPS_IDLE,
		DPS_ADDR,
		DPS_CMD,
		DPS_WDATA,
		DPS_RDATA,
		DPS_IGNORE
	} dps_state_t;

	typedef struct packed {
		logic [6:0]      s1;
		logic [6:0]      s2;
		logic [1:0]      prv;
		logic [2:0]      tog;
		dps_state_t      st;
		logic [3:0]      cnt;
		logic [7:0]      shreg;
		logic [3:0]      op;
		logic [1:0]      sel;
		logic            pot;
		logic [7:0]      rd_byte;
		logic            drv_low;
		logic [7:0]      wiper0;
		logic [7:0]      wiper1;
		logic [7:0][7:0] setting;
		logic            busy;
		logic [20:0]     busy_cnt;
		logic            boot;
	} dps_top_t;

	typedef struct packed {
		logic rx_bit;
		logic rx_tog;
	} dps_rise_t;

	typedef struct packed {
		logic oe;
	} dps_fall_t;

	typedef struct packed {
		logic [255:0] tap_en;
	} dps_dec_t;

	function automatic logic [255:0] dps_onehot(input logic [7:0] pos);
		dps_onehot = 256'h1 << pos;
	endfunction

	function automatic logic [2:0] dps_idx(input logic pot, input logic [1:0] sel);
		dps_idx = {pot, sel};
	endfunction

endpackage

// file: dps_link.sv
`timescale 1ns/1ps
module dps_link
	import dps_pkg::*;
(
	input  wire logic scl_clk,
	input  wire logic rst,
	input  wire logic sda_in,
	input  wire logic drv_low,
	output logic      rx_bit,
	output logic      rx_tog,
	output logic      sda_oe
);

	dps_rise_t rr;
	dps_rise_t rn;
	dps_fall_t fr;
	dps_fall_t fn;

	always_comb
	begin
		rn = rr;
		rn.rx_bit = sda_in;
		rn.rx_tog = ~rr.rx_tog;
		fn.oe = drv_low;
	end

	always_ff @(posedge scl_clk or posedge rst)
	begin
		if (rst)
			rr <= '0;
		else
			rr <= rn;
	end

	// drv_low settles during the high phase, long before the falling edge
	always_ff @(negedge scl_clk or posedge rst)
	begin
		if (rst)
			fr <= '0;
		else
			fr <= fn;
	end

	assign rx_bit = rr.rx_bit;
	assign rx_tog = rr.rx_tog;
	assign sda_oe = fr.oe;

endmodule // dps_link

// file: dps_tap_decoder.sv
`timescale 1ns/1ps
`include "dps_consts.svh"
module dps_tap_decoder
	import dps_pkg::*;
(
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic [7:0]   wiper,
	output logic      [255:0] tap_en
);

	dps_dec_t r;
	dps_dec_t n;

	always_comb
	begin
		n.tap_en = dps_onehot(wiper);
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			r.tap_en <= `DPS_TAP_RESET;
		else
			r <= n;
	end

	assign tap_en = r.tap_en;

endmodule // dps_tap_decoder

// file: dps_two_wire_slave.sv
`timescale 1ns/1ps
`include "dps_consts.svh"
module dps_two_wire_slave
	import dps_pkg::*;
#(
	parameter logic [3:0]  DEVICE_TYPE     = 4'ha,   // Arbitrary value
	parameter int unsigned NV_WRITE_CYCLES = `DPS_NV_WRITE_MS * `DPS_SYS_CLK_KHZ
)
(
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic         scl_clk,
	input  wire logic         sda_in,
	output logic              sda_out,
	output logic              sda_oe,
	input  wire logic [3:0]   addr_strap_pins,
	input  wire logic         write_protect_n,
	output logic      [255:0] tap_en0,
	output logic      [255:0] tap_en1,
	output logic      [7:0]   wiper0,
	output logic      [7:0]   wiper1,
	output logic              nv_busy
);

	dps_top_t r;
	dps_top_t n;
	logic     rx_bit;
	logic     rx_tog;

	// Wiper of the pot named in the command byte
	function automatic logic [7:0] pot_wiper(input dps_top_t s);
		pot_wiper = s.pot ? s.wiper1 : s.wiper0;
	endfunction

	dps_link u_link (
		.scl_clk (scl_clk),
		.rst     (rst),
		.sda_in  (sda_in),
		.drv_low (r.drv_low),
		.rx_bit  (rx_bit),
		.rx_tog  (rx_tog),
		.sda_oe  (sda_oe)
	);

	always_comb
	begin
		logic       scl_s;
		logic       sda_s;
		logic       wp_n_s;
		logic [3:0] straps;
		logic       start;
		logic       stop;
		logic       bit_ev;
		logic [7:0] rx_byte;
		logic       nv_ok;
		logic [2:0] di;
		logic [2:0] d0;
		logic [2:0] d1;
		scl_s   = r.s2[5];
		sda_s   = r.s2[6];
		wp_n_s  = r.s2[4];
		straps  = r.s2[3:0];
		start   = 1'b0;
		stop    = 1'b0;
		bit_ev  = 1'b0;
		rx_byte = {r.shreg[6:0], rx_bit};
		nv_ok   = 1'b0;
		di      = dps_idx(r.pot, r.sel);
		d0      = dps_idx(1'b0, r.sel);
		d1      = dps_idx(1'b1, r.sel);
		n = r;

		// Pins pass two flops; only the second stage is looked at
		n.s1  = {sda_in, scl_clk, write_protect_n, addr_strap_pins};
		n.s2  = r.s1;
		n.prv = {sda_s, scl_s};
		n.tog = {r.tog[1:0], rx_tog};

		start  = scl_s & r.prv[0] & r.prv[1] & ~sda_s;
		stop   = scl_s & r.prv[0] & ~r.prv[1] & sda_s;
		bit_ev = r.tog[2] ^ r.tog[1];
		nv_ok  = wp_n_s;

		// The address stays unacknowledged until this timer runs out
		if (r.busy)
		begin
			if (r.busy_cnt <= 21'h1)
				n.busy = 1'b0;
			n.busy_cnt = r.busy_cnt - 21'h1;
		end

		// Power-up recall of setting zero into each wiper
		if (r.boot)
		begin
			n.boot   = 1'b0;
			n.wiper0 = r.setting[dps_idx(1'b0, 2'h0)];
			n.wiper1 = r.setting[dps_idx(1'b1, 2'h0)];
		end

		// A start wins over a bit event still in flight, so a cut frame never leaks
		if (start)
		begin
			n.st      = DPS_ADDR;
			n.cnt     = 4'h0;
			n.drv_low = 1'b0;
		end
		else if (stop)
		begin
			n.st      = DPS_IDLE;
			n.cnt     = 4'h0;
			n.drv_low = 1'b0;
		end
		else if (bit_ev && r.st != DPS_IDLE && r.st != DPS_IGNORE)
		begin
			n.cnt = r.cnt + 4'h1;
			if (r.cnt < `DPS_BIT_ACK)
				n.shreg = rx_byte;
			case (r.st)
				DPS_ADDR:
				begin
					// Straps are taken fresh each frame, so a strap change needs no reset
					if (r.cnt == `DPS_BIT_LAST)
					begin
						if (rx_byte[`DPS_TYPE_HI:`DPS_TYPE_LO] == DEVICE_TYPE &&
							rx_byte[`DPS_STRAP_HI:`DPS_STRAP_LO] == straps &&
							!r.busy)
							n.drv_low = 1'b1;
						else
						begin
							n.st      = DPS_IGNORE;
							n.drv_low = 1'b0;
						end
					end
					else if (r.cnt == `DPS_BIT_ACK)
					begin
						n.drv_low = 1'b0;
						n.cnt     = 4'h0;
						n.st      = DPS_CMD;
					end
				end
				DPS_CMD:
				begin
					if (r.cnt == `DPS_BIT_LAST)
					begin
						n.op      = rx_byte[`DPS_OP_HI:`DPS_OP_LO];
						n.sel     = rx_byte[`DPS_SEL_HI_POS:`DPS_SEL_LO_POS];
						n.pot     = rx_byte[`DPS_POT_POS];
						n.drv_low = 1'b1;
					end
					// Transfers act at the command acknowledge; no data byte follows
					else if (r.cnt == `DPS_BIT_ACK)
					begin
						n.cnt     = 4'h0;
						n.drv_low = 1'b0;
						n.st      = DPS_IGNORE;
						if (r.op == `DPS_OP_RD_WCR || r.op == `DPS_OP_RD_DR)
						begin
							if (r.op == `DPS_OP_RD_DR)
								n.rd_byte = r.setting[di];
							else
								n.rd_byte = pot_wiper(r);
							n.drv_low = r.op == `DPS_OP_RD_DR ? ~r.setting[di][7] :
								~(r.pot ? r.wiper1[7] : r.wiper0[7]);
							n.st      = DPS_RDATA;
						end
						else if (r.op == `DPS_OP_WR_WCR || r.op == `DPS_OP_WR_DR)
							n.st = DPS_WDATA;
						else if (r.op == `DPS_OP_XFR_D2W)
						begin
							if (r.pot)
								n.wiper1 = r.setting[di];
							else
								n.wiper0 = r.setting[di];
						end
						else if (r.op == `DPS_OP_GXFR_D2W)
						begin
							n.wiper0 = r.setting[d0];
							n.wiper1 = r.setting[d1];
						end
						else if (r.op == `DPS_OP_XFR_W2D && nv_ok)
						begin
							n.setting[di] = pot_wiper(r);
							n.busy        = 1'b1;
							n.busy_cnt    = 21'(NV_WRITE_CYCLES);
						end
						else if (r.op == `DPS_OP_GXFR_W2D && nv_ok)
						begin
							n.setting[d0] = r.wiper0;
							n.setting[d1] = r.wiper1;
							n.busy        = 1'b1;
							n.busy_cnt    = 21'(NV_WRITE_CYCLES);
						end
					end
				end
				DPS_WDATA:
				begin
					// Setting writes commit here, not at the stop, so polling may start at once
					if (r.cnt == `DPS_BIT_LAST)
					begin
						n.drv_low = 1'b1;
						if (r.op == `DPS_OP_WR_WCR)
						begin
							if (r.pot)
								n.wiper1 = rx_byte;
							else
								n.wiper0 = rx_byte;
						end
						else if (nv_ok)
						begin
							n.setting[di] = rx_byte;
							n.busy        = 1'b1;
							n.busy_cnt    = 21'(NV_WRITE_CYCLES);
						end
					end
					else if (r.cnt == `DPS_BIT_ACK)
					begin
						n.drv_low = 1'b0;
						n.st      = DPS_IGNORE;
					end
				end
				DPS_RDATA:
				begin
					// Next bit is placed now and goes out at the next falling edge
					if (r.cnt < `DPS_BIT_LAST)
					begin
						n.rd_byte = {r.rd_byte[6:0], 1'b0};
						n.drv_low = ~r.rd_byte[6];
					end
					else if (r.cnt == `DPS_BIT_LAST)
						n.drv_low = 1'b0;
					else
						n.st = DPS_IGNORE;
				end
				default:
					n.drv_low = 1'b0;
			endcase
		end
	end

	// Settings come up at mid-scale; no real nonvolatile store stands behind them
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			r         <= '0;
			r.st      <= DPS_IDLE;
			r.wiper0  <= `DPS_SETTING_RESET;
			r.wiper1  <= `DPS_SETTING_RESET;
			r.setting <= {8{`DPS_SETTING_RESET}};
			r.boot    <= 1'b1;
		end
		else
			r <= n;
	end

	// Decoders add one cycle so the wide one-hot stays off the control path
	dps_tap_decoder u_dec0 (
		.sys_clk (sys_clk),
		.rst     (rst),
		.wiper   (r.wiper0),
		.tap_en  (tap_en0)
	);

	dps_tap_decoder u_dec1 (
		.sys_clk (sys_clk),
		.rst     (rst),
		.wiper   (r.wiper1),
		.tap_en  (tap_en1)
	);

	// Open drain: the pad only ever pulls low, the pull-up gives the high level
	assign sda_out = 1'b0;
	assign wiper0  = r.wiper0;
	assign wiper1  = r.wiper1;
	assign nv_busy = r.busy;

endmodule // dps_two_wire_slave

// file: dps_two_wire_slave_monitor.sv
`timescale 1ns/1ps
module dps_two_wire_slave_monitor
#(
	parameter int unsigned NV_WRITE_CYCLES = 2000000
)
(
	input wire logic         sys_clk,
	input wire logic         rst,
	input wire logic         scl_clk,
	input wire logic         sda_in,
	input wire logic         sda_out,
	input wire logic         sda_oe,
	input wire logic [3:0]   addr_strap_pins,
	input wire logic         write_protect_n,
	input wire logic [255:0] tap_en0,
	input wire logic [255:0] tap_en1,
	input wire logic [7:0]   wiper0,
	input wire logic [7:0]   wiper1,
	input wire logic         nv_busy
);
	logic [21:0] bcnt_r;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Busy length is counted, too long for a repetition
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
			bcnt_r <= 22'h0;
		else
			bcnt_r <= nv_busy ? bcnt_r + 22'h1 : 22'h0;
	sequence s_ack_held;
		sda_oe [*8];
	endsequence
	property p_onehot;
		$onehot(tap_en0) && $onehot(tap_en1);
	endproperty
	property p_dec0;
		!$past(rst) |-> tap_en0 == (256'h1 << $past(wiper0));
	endproperty
	property p_dec1;
		!$past(rst) |-> tap_en1 == (256'h1 << $past(wiper1));
	endproperty
	property p_od;
		sda_out == 1'b0;
	endproperty
	property p_oe_rise;
		$rose(sda_oe) |-> !scl_clk;
	endproperty
	property p_oe_fall;
		$fell(sda_oe) |-> !scl_clk;
	endproperty
	property p_ack_len;
		$rose(sda_oe) |-> s_ack_held;
	endproperty
	property p_busy;
		$fell(nv_busy) |-> bcnt_r >= NV_WRITE_CYCLES - 1 && bcnt_r <= NV_WRITE_CYCLES + 1;
	endproperty
	property p_boot;
		$fell(rst) |-> wiper0 == 8'h80 && wiper1 == 8'h80;
	endproperty
	a_onehot: assert property (p_onehot) else $error("tap not one-hot");
	a_dec0: assert property (p_dec0) else $error("tap 0 decode");
	a_dec1: assert property (p_dec1) else $error("tap 1 decode");
	a_od: assert property (p_od) else $error("data driven high");
	a_oe_rise: assert property (p_oe_rise) else $error("drive rose, clock high");
	a_oe_fall: assert property (p_oe_fall) else $error("release, clock high");
	a_ack_len: assert property (p_ack_len) else $error("low pulse short");
	a_busy: assert property (p_busy) else $error("busy length");
	a_boot: assert property (p_boot) else $error("boot wiper");
endmodule // dps_two_wire_slave_monitor

bind dps_two_wire_slave dps_two_wire_slave_monitor #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) i_mon (
	.sys_clk(sys_clk), .rst(rst), .scl_clk(scl_clk), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .addr_strap_pins(addr_strap_pins), .write_protect_n(write_protect_n),
	.tap_en0(tap_en0), .tap_en1(tap_en1), .wiper0(wiper0), .wiper1(wiper1),
	.nv_busy(nv_busy));

// file: dps_bus_master.sv
`timescale 1ns/1ps
module dps_bus_master (
	input  wire logic tclk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	// Clock idles high between frames; only this side drives it
	initial scl = 1'b1;
	initial sda_low = 1'b0;
	task automatic ph;
		repeat (4) @(posedge tclk);
	endtask
	task automatic start;
		sda_low <= 1'b0;
		ph;
		scl <= 1'b1;
		ph;
		sda_low <= 1'b1;
		ph;
		scl <= 1'b0;
		ph;
	endtask
	task automatic stop;
		sda_low <= 1'b1;
		ph;
		scl <= 1'b1;
		ph;
		sda_low <= 1'b0;
		ph;
	endtask
	// Data moves a phase away from the fall, so no false start
	task automatic clk_bit(input logic b, output logic r);
		sda_low <= !b;
		ph;
		scl <= 1'b1;
		ph;
		r = sda;
		scl <= 1'b0;
		ph;
	endtask
	task automatic wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], r);
		clk_bit(1'b1, r);
		ack = !r;
	endtask
	task automatic rd(output logic [7:0] d, input logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			clk_bit(1'b1, d[i]);
		clk_bit(!ack, r);
	endtask
endmodule // dps_bus_master

// file: test_dps_two_wire_slave.sv
`timescale 1ns/1ps
module test_dps_two_wire_slave;
	localparam logic [3:0] TYPE = 4'ha; // Arbitrary value
	logic         sys_clk, rst, tclk, scl, m_low, wp_n, sda_w, oe, od, busy;
	logic [3:0]   strap;
	logic [7:0]   w0, w1;
	logic [255:0] t0, t1;
	int           n_fail, n_tests;
	assign sda_w = !(m_low || (oe && !od));
	dps_two_wire_slave #(.DEVICE_TYPE(TYPE), .NV_WRITE_CYCLES(600)) i_dut (
		.sys_clk(sys_clk), .rst(rst), .scl_clk(scl), .sda_in(sda_w), .sda_out(od),
		.sda_oe(oe), .addr_strap_pins(strap), .write_protect_n(wp_n), .tap_en0(t0),
		.tap_en1(t1), .wiper0(w0), .wiper1(w1), .nv_busy(busy));
	dps_bus_master i_mst (.tclk(tclk), .sda(sda_w), .scl(scl), .sda_low(m_low));
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = !sys_clk;
	end
	initial
	begin
		tclk = 1'b0;
		#1.7;
		forever #6 tclk = !tclk;
	end
	initial
	begin
		#300000;
		n_fail++;
		end_sim;
	end
	task automatic chk(input logic [255:0] got, input logic [255:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("%0d checks, %0d mismatches", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic settle;
		repeat (3) @(negedge sys_clk);
	endtask
	task automatic hdr(input logic [7:0] cmd);
		logic a;
		i_mst.start;
		i_mst.wr({TYPE, strap}, a);
		chk(a, 1'b1);
		i_mst.wr(cmd, a);
		chk(a, 1'b1);
	endtask
	task automatic put(input logic [7:0] cmd, input logic [7:0] d);
		logic a;
		hdr(cmd);
		i_mst.wr(d, a);
		chk(a, 1'b1);
		i_mst.stop;
		settle;
	endtask
	task automatic xfr;
		hdr(8'hd9);
		i_mst.stop;
		settle;
	endtask
	task automatic wait_idle;
		for (int i = 0; busy && i < 2000; i++)
			@(negedge sys_clk);
		if (busy !== 1'b0)
		begin
			n_fail++;
			end_sim;
		end
	endtask
	task automatic t_reset;
		chk(w0, 8'h80);
		chk(w1, 8'h80);
		chk(t1, 256'h1 << 128);
	endtask
	task automatic t_wiper;
		logic [7:0] d;
		put(8'ha0, 8'h5a);
		put(8'ha1, 8'hff);
		chk(w0, 8'h5a);
		chk(t0, 256'h1 << 8'h5a);
		chk(t1, 256'h1 << 255);
		hdr(8'h90);
		i_mst.rd(d, 1'b0);
		i_mst.stop;
		chk(d, 8'h5a);
	endtask
	task automatic t_addr;
		logic a;
		for (int i = 0; i < 2; i++)
		begin
			i_mst.start;
			i_mst.wr(i ? {TYPE, ~strap} : {~TYPE, strap}, a);
			chk(a, 1'b0);
			i_mst.wr(8'ha0, a);
			i_mst.wr(8'h00, a);
			i_mst.stop;
			settle;
			chk(w0, 8'h5a);
		end
	endtask
	task automatic t_nv;
		logic a;
		put(8'hc9, 8'h3c);
		i_mst.start;
		i_mst.wr({TYPE, strap}, a);
		i_mst.stop;
		chk(a, 1'b0);
		wait_idle;
		xfr;
		chk(w1, 8'h3c);
		@(posedge sys_clk);
		wp_n <= 1'b0;
		put(8'hc9, 8'h11);
		wait_idle;
		xfr;
		chk(w1, 8'h3c);
		@(posedge sys_clk);
		wp_n <= 1'b1;
	endtask
	task automatic t_rstart;
		logic r;
		i_mst.start;
		for (int i = 3; i > 0; i--)
			i_mst.clk_bit(TYPE[i], r);
		put(8'ha0, 8'h00);
		chk(w0, 8'h00);
		chk(t0, 256'h1);
	endtask
	initial
	begin
		rst = 1'b1;
		wp_n = 1'b1;
		strap = 4'h6;
		n_fail = 0;
		n_tests = 0;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		settle;
		t_reset;
		t_wiper;
		t_addr;
		t_nv;
		t_rstart;
		end_sim;
	end
endmodule // test_dps_two_wire_slave
